// ---- shared/chc_pkg.sv ----
package chc_pkg;
  localparam int CLK_HZ = 20_000_000;
  // Time of the auto-mode result pulse, in nanoseconds.
  localparam int RDY_PULSE_NS = 1000;
  localparam int RDY_PULSE_CYC =
    (RDY_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int NUM_CH = 4;
  localparam int CONV_CYC = 8;
  localparam int NUM_GPIO = 4;
  localparam int DAC_W = 12;
  localparam int GRP_DACS = 6;
  localparam logic [11:0] DAC_CLEAR_CODE = 12'h000;
  localparam logic [NUM_CH-1:0] LIMIT_RST = 4'h0;
  // Host-side divider for the link clock half period.
  localparam int LINK_HALF_CYC = 4;
  // Shortest I2C clock the host uses stays above 1 kHz.
  localparam int I2C_MIN_HZ = 1000;
  typedef enum logic [1:0] {ChcIdle, ChcConv, ChcDone} chc_state_t;
endpackage

// ---- shared/chc_if.sv ----
`timescale 1ns/1ps
interface chc_if;
  logic       ifaceSpiSel;
  logic       linkClk;
  logic       extConvTriggerN;
  logic       resetN;
  logic       dacGroup0ClearN;
  logic       dacGroup1ClearN;
  logic       selectOrAddrBit0;
  logic       serialOutOrAddrBit1Dev;
  logic       serialOutOrAddrBit1Oe;
  logic       slaveAddrBit2;
  logic       resultReadyN;
  logic       alarmOutOe;
  logic [3:0] gpioOutDev;
  logic [3:0] gpioOe;
  logic [3:0] gpioHostOe;
  logic [3:0] gpioLine;
  logic       alarmLine;
  logic       addrBit1Host;
  logic       serialOutOrAddrBit1Line;
  assign alarmLine = alarmOutOe;
  // The shared pin carries the host strap only while the device lets go.
  assign serialOutOrAddrBit1Line = serialOutOrAddrBit1Oe ? addrBit1Host
                                                         : serialOutOrAddrBit1Dev;
  assign gpioLine = gpioOe & gpioHostOe;
  modport dev (input ifaceSpiSel, linkClk, extConvTriggerN, resetN,
    dacGroup0ClearN, dacGroup1ClearN, selectOrAddrBit0, slaveAddrBit2,
    gpioLine, serialOutOrAddrBit1Line,
    output serialOutOrAddrBit1Dev, serialOutOrAddrBit1Oe,
    resultReadyN, alarmOutOe, gpioOutDev, gpioOe);
  modport host (output ifaceSpiSel, linkClk, extConvTriggerN, resetN,
    dacGroup0ClearN, dacGroup1ClearN, selectOrAddrBit0, slaveAddrBit2,
    gpioHostOe, addrBit1Host, input resultReadyN, alarmLine, gpioLine,
    serialOutOrAddrBit1Dev);
endinterface

// ---- rtl/chc_sync.sv ----
`timescale 1ns/1ps
module chc_sync
  import chc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         rst,
  input  wire logic [W-1:0] asyncIn,
  output logic      [W-1:0] syncOut
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] sync_nxt;
  always_comb begin
    meta_nxt = asyncIn;
    sync_nxt = meta_r;
  end
  // Reset value is high so active-low pins look idle.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_r  <= '1;
      syncOut <= '1;
    end else begin
      meta_r  <= meta_nxt;
      syncOut <= sync_nxt;
    end
  end
endmodule

// ---- rtl/chc_device.sv ----
`timescale 1ns/1ps
// Function
// - High select enables SPI, low enables I2C.
// - Shared pins: chip select/output or address.
// - Trigger falling edge starts conversion.
// - Direct mode: ready goes low at end.
// - Auto mode: 1 us low pulse per cycle.
// - Ready output idles high.
// - Alarm pulled low when channel out of range.
// - Clear low loads clear code into latch.
// - Clear leaves data registers unchanged.
// - Clear release reloads latch from data.
// - Reset pin low resets device, except synchronizers.
// - Sensor pins are GPIO when sensor off.
// - GPIO pins are open-drain, drive low only.
// - Host keeps I2C clock at least 1 kHz.
// - I2C supports 100k, 400k, 3.4M clocks.
// - New trigger aborts and restarts sequence.
// - Direct converts once; auto repeats.
module chc_device
  import chc_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  chc_if.dev                          pins,
  input  wire logic                   conv_mode_select,
  input  wire logic                   soft_conv_trigger_bit,
  input  wire logic [NUM_CH-1:0]      chanOutOfRange,
  input  wire logic [DAC_W-1:0]       dacData [2*GRP_DACS],
  input  wire logic                   sensor1Enable,
  input  wire logic                   sensor2Enable,
  input  wire logic [NUM_GPIO-1:0]    gpioDriveLow,
  output logic                        spiActive,
  output logic [2:0]                  slaveAddr,
  output logic                        spiChipSelect,
  output logic [DAC_W-1:0]            dacLatch [2*GRP_DACS],
  output logic [NUM_GPIO-1:0]         gpioIn,
  output logic [1:0]                  channelIndex,
  output logic                        remote_sensor1_pos_or_io,
  output logic                        remote_sensor2_neg_or_io
);
  logic [8:0] pinSync;
  logic [3:0] gpioSync;
  chc_sync #(.W(9)) uSyncCtl (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn ({pins.serialOutOrAddrBit1Line,
               pins.ifaceSpiSel, pins.linkClk, pins.extConvTriggerN,
               pins.resetN, pins.dacGroup0ClearN, pins.dacGroup1ClearN,
               pins.selectOrAddrBit0, pins.slaveAddrBit2}),
    .syncOut (pinSync)
  );
  chc_sync #(.W(4)) uSyncIo (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn (pins.gpioLine),
    .syncOut (gpioSync)
  );
  logic spiSel, trigN, resetPinN, clr0N, clr1N, csA0, a1, a2;
  assign a1        = pinSync[8];
  assign spiSel    = pinSync[7];
  assign trigN     = pinSync[5];
  assign resetPinN = pinSync[4];
  assign clr0N     = pinSync[3];
  assign clr1N     = pinSync[2];
  assign csA0      = pinSync[1];
  assign a2        = pinSync[0];
  // Device state outside the synchronizers resets from either source.
  logic fullRst;
  assign fullRst = rst | ~resetPinN;

  chc_state_t state_r, state_nxt;
  logic       trigPrev_r, trigPrev_nxt;
  logic [1:0] chan_r, chan_nxt;
  logic [3:0] convCnt_r, convCnt_nxt;
  logic [7:0] pulseCnt_r, pulseCnt_nxt;
  logic       ready_r, ready_nxt;
  logic       alarmOe_r, alarmOe_nxt;
  logic       spi_r, spi_nxt;
  logic [2:0] addr_r, addr_nxt;
  logic       cs_r, cs_nxt;
  logic       sdoOe_r, sdoOe_nxt;
  logic [NUM_GPIO-1:0] gpioOe_r, gpioOe_nxt;
  logic [NUM_GPIO-1:0] gpioIn_r, gpioIn_nxt;
  logic       s1_r, s1_nxt, s2_r, s2_nxt;
  logic       trig;

  always_comb begin
    trig = (trigPrev_r & ~trigN) | soft_conv_trigger_bit;
    trigPrev_nxt = trigN;
    state_nxt    = state_r;
    chan_nxt     = chan_r;
    convCnt_nxt  = convCnt_r;
    pulseCnt_nxt = (pulseCnt_r != 8'h00) ? pulseCnt_r - 8'h01 : 8'h00;
    ready_nxt    = ready_r;
    if (trig) begin
      state_nxt   = ChcConv;
      chan_nxt    = 2'h0;
      convCnt_nxt = 4'h0;
      ready_nxt   = 1'b1;
    end else begin
      case (state_r)
        ChcIdle: state_nxt = ChcIdle;
        ChcConv: begin
          if (convCnt_r == 4'(CONV_CYC - 1)) begin
            convCnt_nxt = 4'h0;
            if (chan_r == 2'(NUM_CH - 1)) begin
              chan_nxt = 2'h0;
              if (conv_mode_select) begin
                pulseCnt_nxt = 8'(RDY_PULSE_CYC);
              end else begin
                state_nxt = ChcDone;
                ready_nxt = 1'b0;
              end
            end else begin
              chan_nxt = chan_r + 2'h1;
            end
          end else begin
            convCnt_nxt = convCnt_r + 4'h1;
          end
        end
        ChcDone: state_nxt = ChcDone;
        default: state_nxt = ChcIdle;
      endcase
    end
    if (conv_mode_select) begin
      ready_nxt = (pulseCnt_nxt == 8'h00);
    end
    alarmOe_nxt = ~(|chanOutOfRange);
    spi_nxt     = spiSel;
    addr_nxt    = spiSel ? 3'h0 : {a2, a1, csA0};
    cs_nxt      = spiSel ? csA0 : 1'b1;
    sdoOe_nxt   = ~spiSel;
    gpioOe_nxt  = ~gpioDriveLow;
    gpioIn_nxt  = gpioSync;
    s1_nxt      = sensor1Enable ? 1'b0 : gpioSync[0];
    s2_nxt      = sensor2Enable ? 1'b0 : gpioSync[1];
  end

  always_ff @(posedge clk_sys) begin
    if (fullRst) begin
      state_r    <= ChcIdle;
      trigPrev_r <= 1'b1;
      chan_r     <= 2'h0;
      convCnt_r  <= 4'h0;
      pulseCnt_r <= 8'h00;
      ready_r    <= 1'b1;
      alarmOe_r  <= 1'b1;
      spi_r      <= 1'b0;
      addr_r     <= 3'h0;
      cs_r       <= 1'b1;
      sdoOe_r    <= 1'b1;
      gpioOe_r   <= '1;
      gpioIn_r   <= '1;
      s1_r       <= 1'b0;
      s2_r       <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      trigPrev_r <= trigPrev_nxt;
      chan_r     <= chan_nxt;
      convCnt_r  <= convCnt_nxt;
      pulseCnt_r <= pulseCnt_nxt;
      ready_r    <= ready_nxt;
      alarmOe_r  <= alarmOe_nxt;
      spi_r      <= spi_nxt;
      addr_r     <= addr_nxt;
      cs_r       <= cs_nxt;
      sdoOe_r    <= sdoOe_nxt;
      gpioOe_r   <= gpioOe_nxt;
      gpioIn_r   <= gpioIn_nxt;
      s1_r       <= s1_nxt;
      s2_r       <= s2_nxt;
    end
  end

  // Data registers are inputs here, so clear never touches them.
  logic [DAC_W-1:0] latch_nxt [2*GRP_DACS];
  genvar gi;
  generate
    for (gi = 0; gi < 2*GRP_DACS; gi++) begin : gDac
      always_comb begin
        if (gi < GRP_DACS ? ~clr0N : ~clr1N) begin
          latch_nxt[gi] = DAC_CLEAR_CODE;
        end else begin
          latch_nxt[gi] = dacData[gi];
        end
      end
      always_ff @(posedge clk_sys) begin
        if (fullRst) begin
          dacLatch[gi] <= DAC_CLEAR_CODE;
        end else begin
          dacLatch[gi] <= latch_nxt[gi];
        end
      end
    end
  endgenerate

  assign pins.resultReadyN           = ready_r;
  assign pins.alarmOutOe             = alarmOe_r;
  assign pins.serialOutOrAddrBit1Dev = 1'b0;
  assign pins.serialOutOrAddrBit1Oe  = sdoOe_r;
  assign pins.gpioOutDev             = 4'h0;
  assign pins.gpioOe                 = gpioOe_r;
  assign spiActive                   = spi_r;
  assign slaveAddr                   = addr_r;
  assign spiChipSelect               = cs_r;
  assign gpioIn                      = gpioIn_r;
  assign channelIndex                = chan_r;
  assign remote_sensor1_pos_or_io    = s1_r;
  assign remote_sensor2_neg_or_io    = s2_r;
endmodule

// ---- rtl/chc_host.sv ----
`timescale 1ns/1ps
module chc_host
  import chc_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rst,
  chc_if.host                      pins,
  input  wire logic                useSpi,
  input  wire logic [2:0]          addrStrap,
  input  wire logic                convReq,
  input  wire logic                resetReq,
  input  wire logic                clear0Req,
  input  wire logic                clear1Req,
  input  wire logic [NUM_GPIO-1:0] gpioPullLow,
  output logic                     resultReady,
  output logic                     alarmActive,
  output logic [NUM_GPIO-1:0]      gpioLevel
);
  logic [5:0] inSync;
  chc_sync #(.W(6)) uSyncIn (
    .clk_sys (clk_sys),
    .rst     (rst),
    .asyncIn ({pins.resultReadyN, pins.alarmLine, pins.gpioLine}),
    .syncOut (inSync)
  );
  logic [2:0] div_r, div_nxt;
  logic       lclk_r, lclk_nxt, trigN_r, trigN_nxt, rstN_r, rstN_nxt;
  logic       c0_r, c0_nxt, c1_r, c1_nxt, sel_r, sel_nxt;
  logic [2:0] addr_r, addr_nxt;
  logic [3:0] gOe_r, gOe_nxt;
  logic       rdy_r, rdy_nxt, alm_r, alm_nxt;
  logic [3:0] gLvl_r, gLvl_nxt;
  always_comb begin
    // Link clock divided down to 2.5 MHz; below the 3.4 MHz ceiling.
    div_nxt  = (div_r == 3'(LINK_HALF_CYC - 1)) ? 3'h0 : div_r + 3'h1;
    // Half period of a few cycles keeps the clock well above 1 kHz.
    lclk_nxt = (div_r == 3'(LINK_HALF_CYC - 1)) ? ~lclk_r
                                                 : lclk_r;
    trigN_nxt = ~convReq;
    rstN_nxt  = ~resetReq;
    c0_nxt    = ~clear0Req;
    c1_nxt    = ~clear1Req;
    sel_nxt   = useSpi;
    addr_nxt  = addrStrap;
    gOe_nxt   = ~gpioPullLow;
    rdy_nxt   = ~inSync[5];
    alm_nxt   = ~inSync[4];
    gLvl_nxt  = inSync[3:0];
  end
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      div_r <= 3'h0; lclk_r <= 1'b1; trigN_r <= 1'b1; rstN_r <= 1'b1;
      c0_r <= 1'b1; c1_r <= 1'b1; sel_r <= 1'b1; addr_r <= 3'h0;
      gOe_r <= '1; rdy_r <= 1'b0; alm_r <= 1'b0; gLvl_r <= '1;
    end else begin
      div_r <= div_nxt; lclk_r <= lclk_nxt; trigN_r <= trigN_nxt;
      rstN_r <= rstN_nxt; c0_r <= c0_nxt; c1_r <= c1_nxt;
      sel_r <= sel_nxt; addr_r <= addr_nxt; gOe_r <= gOe_nxt;
      rdy_r <= rdy_nxt; alm_r <= alm_nxt; gLvl_r <= gLvl_nxt;
    end
  end
  assign pins.linkClk          = lclk_r;
  assign pins.extConvTriggerN  = trigN_r;
  assign pins.resetN           = rstN_r;
  assign pins.dacGroup0ClearN  = c0_r;
  assign pins.dacGroup1ClearN  = c1_r;
  assign pins.ifaceSpiSel      = sel_r;
  assign pins.selectOrAddrBit0 = sel_r ? 1'b1 : addr_r[0];
  assign pins.slaveAddrBit2    = addr_r[2];
  assign pins.addrBit1Host     = sel_r ? 1'b1 : addr_r[1];
  assign pins.gpioHostOe       = gOe_r;
  assign resultReady           = rdy_r;
  assign alarmActive           = alm_r;
  assign gpioLevel             = gLvl_r;
endmodule

// ---- sim/chc_sva.sv ----
`timescale 1ns/1ps
module chc_sva (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       ifaceSpiSel,
  input wire logic       linkClk,
  input wire logic       extConvTriggerN,
  input wire logic       resetN,
  input wire logic       serialOutOrAddrBit1Dev,
  input wire logic       serialOutOrAddrBit1Oe,
  input wire logic       resultReadyN,
  input wire logic       alarmOutOe,
  input wire logic [3:0] gpioOutDev,
  input wire logic [3:0] gpioOe
);
  logic [5:0] sinceTrig_r;
  logic       trigPrev_r;
  logic       sawDone_r;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // A device reset parks the count, so no stale trigger can be blamed.
  always_ff @(posedge clk_sys) begin
    if (rst || !resetN) begin
      sinceTrig_r <= 6'h3F;
      trigPrev_r <= 1'b1;
      sawDone_r <= 1'b0;
    end else begin
      trigPrev_r <= extConvTriggerN;
      if (trigPrev_r && !extConvTriggerN) begin
        sinceTrig_r <= 6'h00;
        sawDone_r <= 1'b0;
      end else begin
        if (sinceTrig_r != 6'h3F) sinceTrig_r <= sinceTrig_r + 6'h01;
        if (!resultReadyN && sinceTrig_r >= 6'h20) sawDone_r <= 1'b1;
      end
    end
  end
  AST_SDO_I2C: assert property (
    (!ifaceSpiSel)[*6] |-> serialOutOrAddrBit1Oe)
    else $error("Shared output driven in I2C mode.");
  AST_SDO_SPI: assert property (
    (ifaceSpiSel && resetN)[*6] |->
      !serialOutOrAddrBit1Oe && !serialOutOrAddrBit1Dev)
    else $error("Shared output not driven in SPI mode.");
  AST_RESET_IDLE: assert property (
    (!resetN)[*5] |-> resultReadyN && alarmOutOe)
    else $error("Outputs not idle during pin reset.");
  AST_GPIO_LOW_ONLY: assert property (
    (gpioOutDev & ~gpioOe) == 4'h0)
    else $error("Pin driven high.");
  AST_NO_EARLY_DONE: assert property (
    $fell(resultReadyN) |-> sinceTrig_r >= 6'h20)
    else $error("Ready came before a full sequence.");
  AST_DONE_IN_TIME: assert property (
    sinceTrig_r == 6'h28 |-> sawDone_r)
    else $error("No ready after a trigger.");
  AST_LINK_HALF: assert property (
    $changed(linkClk) |=> $stable(linkClk)[*3])
    else $error("Link clock half period too short.");
  AST_READY_HOLD: assert property (
    $fell(resultReadyN) && resetN && extConvTriggerN |=>
      (!resultReadyN)[*3])
    else $error("Ready pulse too short.");
endmodule

// ---- sim/testbench.sv ----
`timescale 1ns/1ps
module testbench
  import chc_pkg::*;
;
  logic                clk_sys = 1'b0;
  logic                rst, useSpi, convReq, resetReq, clear0Req, clear1Req;
  logic                resultReady, alarmActive, spiActive, modeAuto;
  logic                softTrig, sens1, sens2, rs1, rs2, spiCs;
  logic [2:0]          addrStrap, slaveAddr;
  logic [NUM_GPIO-1:0] gpioPullLow, gpioDriveLow, gpioLevel, gpioIn;
  logic [NUM_CH-1:0]   outOfRange;
  logic [DAC_W-1:0]    dacData [2*GRP_DACS];
  logic [DAC_W-1:0]    dacLatch [2*GRP_DACS];
  logic [31:0]         seed = 32'h0000_0004;
  logic [31:0]         r;
  int                  cyc = 0;
  int                  tTrig, n_fail, comparisons;
  int                  q[$];
  chc_if bus ();
  chc_host u_chc_host (.clk_sys, .rst, .pins(bus.host), .useSpi, .addrStrap,
    .convReq, .resetReq, .clear0Req, .clear1Req, .gpioPullLow,
    .resultReady, .alarmActive, .gpioLevel);
  chc_device u_chc_device (.clk_sys, .rst, .pins(bus.dev),
    .conv_mode_select(modeAuto), .soft_conv_trigger_bit(softTrig),
    .chanOutOfRange(outOfRange), .dacData, .sensor1Enable(sens1),
    .sensor2Enable(sens2), .gpioDriveLow, .spiActive, .slaveAddr,
    .spiChipSelect(spiCs), .dacLatch, .gpioIn, .channelIndex(),
    .remote_sensor1_pos_or_io(rs1), .remote_sensor2_neg_or_io(rs2));
  chc_sva u_chc_sva (.clk_sys, .rst, .ifaceSpiSel(bus.ifaceSpiSel),
    .linkClk(bus.linkClk), .extConvTriggerN(bus.extConvTriggerN),
    .resetN(bus.resetN), .serialOutOrAddrBit1Dev(bus.serialOutOrAddrBit1Dev),
    .serialOutOrAddrBit1Oe(bus.serialOutOrAddrBit1Oe),
    .resultReadyN(bus.resultReadyN), .alarmOutOe(bus.alarmOutOe),
    .gpioOutDev(bus.gpioOutDev), .gpioOe(bus.gpioOe));
  initial begin
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  // The host turns the level request into a trigger edge on the link.
  task automatic trig();
    tTrig = cyc;
    convReq = 1'b1;
    step(2);
    convReq = 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    close_out();
  end
  // Every falling ready edge is matched with the oldest expected result.
  initial begin : watch
    int w;
    int base;
    forever begin
      @(negedge bus.resultReadyN);
      #1;
      base = (q.size() > 0) ? q.pop_front() : -100;
      chk("latency", (cyc - tTrig - base) inside {[30:44]}, 1'b1);
      w = 0;
      while (bus.resultReadyN === 1'b0 && w < 30) begin
        @(posedge clk_sys);
        #1;
        w++;
        if (w == 8) chk("resultReady", resultReady, 1'b1);
      end
      chk("readyWidth", 16'(w), 16'(modeAuto ? RDY_PULSE_CYC : 30));
    end
  end
  initial begin
    {rst, useSpi, convReq, resetReq, clear0Req, clear1Req} = 6'h20;
    {modeAuto, softTrig, sens1, sens2, addrStrap} = 7'h00;
    {gpioPullLow, gpioDriveLow, outOfRange} = 12'h000;
    foreach (dacData[i]) dacData[i] = 12'h000;
    repeat (4) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    step(6);
    for (int u = 0; u < 2; u++) begin
      r = rnd();
      useSpi = u[0];
      addrStrap = r[2:0];
      step(10);
      chk("spiActive", spiActive, useSpi);
      chk("slaveAddr", slaveAddr,
          useSpi ? 3'h0 : r[2:0]);
      chk("spiChipSelect", spiCs, 1'b1);
    end
    repeat (4) begin
      r = rnd();
      {sens2, sens1, gpioPullLow, gpioDriveLow} = r[9:0];
      step(8);
      chk("gpioLevel", gpioLevel, 4'(~(r[3:0] | r[7:4])));
      chk("gpioIn", gpioIn, 4'(~(r[3:0] | r[7:4])));
      chk("sensor1Io", rs1, sens1 ? 1'b0 : !(r[0] | r[4]));
      chk("sensor2Io", rs2, sens2 ? 1'b0 : !(r[1] | r[5]));
    end
    for (int k = 0; k < 2; k++) begin
      r = rnd();
      outOfRange = (k != 0) ? 4'h0 : (r[3:0] | 4'h1);
      step(8);
      chk("alarmActive", alarmActive, k == 0);
      chk("alarmLine", bus.alarmLine, k != 0);
    end
    foreach (dacData[i]) begin
      r = rnd();
      dacData[i] = r[11:0];
    end
    for (int g = 0; g < 3; g++) begin
      clear0Req = (g == 0);
      clear1Req = (g == 1);
      step(10);
      foreach (dacLatch[i]) chk("dacLatch", dacLatch[i],
        (i / GRP_DACS == g) ? DAC_CLEAR_CODE : dacData[i]);
    end
    q.push_back(0);
    trig();
    step(70);
    trig();
    step(15);
    q.push_back(0);
    trig();
    step(70);
    q.push_back(0);
    tTrig = cyc;
    softTrig = 1'b1;
    step(1);
    softTrig = 1'b0;
    step(70);
    modeAuto = 1'b1;
    q.push_back(0);
    q.push_back(32);
    trig();
    step(88);
    resetReq = 1'b1;
    step(6);
    resetReq = 1'b0;
    step(10);
    chk("readyAfterReset", bus.resultReadyN, 1'b1);
    chk("pendingResults", 16'(q.size()), 16'h0000);
    close_out();
  end
endmodule
